//--- design/rhpc_top.sv
// root hub port 1 control: axi4-lite registers, port sequencing and status bits
`timescale 1ns/1ps
module rhpc_top #(
  parameter int RESET_CYCLES  = rhpc_pkg::RESET_CYCLES,
  parameter int RESUME_CYCLES = rhpc_pkg::RESUME_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // port side
  input  wire logic        dev_attached,
  output logic             port_reset_drive,
  output logic             port_resume_drive,
  output logic             port_suspended,
  output logic             port_enabled
);

  // write-one test on a field, honouring its byte strobe
  function automatic logic w1(input logic [31:0] d, input logic [3:0] s, input int pos);
    w1 = d[pos] & s[pos / 8];
  endfunction

  // true when an address selects a given register word
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_go;
  logic        wr_port;
  logic        wr_desc;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [31:0] rd_value;

  logic        set_reset;
  logic        clr_suspend;
  logic        set_suspend;
  logic        set_enable;
  logic        clr_enable;
  logic        clr_connect_chg;
  logic        clr_suspend_chg;
  logic        clr_reset_chg;

  logic        attach_q;
  logic        ccs;
  logic        ccs_q;
  logic        nonremovable;
  logic        pes;
  logic        connect_change_flag;
  logic        pssc;
  logic        reset_change_flag;

  rhpc_pkg::rhpc_state_t state;
  rhpc_pkg::rhpc_state_t next_state;

  logic                           tmr_start;
  logic [rhpc_pkg::TIMER_W-1:0]   tmr_load;
  logic                           tmr_done;
  logic                           end_reset;
  logic                           end_resume;

  // ---------------- axi write channel ----------------
  // address and data are taken in either order; the write acts once both are held
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      wr_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_wready <= 1'b1;
      wr_data      <= 32'h00000000;
      wr_strb      <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data      <= s_axi_wdata;
      wr_strb      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // response rises on the edge where the write takes effect
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rhpc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? rhpc_pkg::RESP_OKAY : rhpc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_port   = wr_go && hit(wr_addr, rhpc_pkg::PORT1_STATUS_CONTROL_OFF);
  assign wr_desc   = wr_go && hit(wr_addr, rhpc_pkg::ROOT_HUB_DESCRIPTOR_B_OFF);
  assign wr_mapped = hit(wr_addr, rhpc_pkg::PORT1_STATUS_CONTROL_OFF) ||
                     hit(wr_addr, rhpc_pkg::ROOT_HUB_DESCRIPTOR_B_OFF);

  // write-one strobes; zeros and the reserved bits carry no effect
  assign set_reset   = wr_port && w1(wr_data, wr_strb, rhpc_pkg::RESET_STATUS_SET_RESET_BIT);
  assign clr_suspend = wr_port && w1(wr_data, wr_strb, rhpc_pkg::OVERCURRENT_CLEAR_SUSPEND_BIT);
  assign set_suspend = wr_port && w1(wr_data, wr_strb, rhpc_pkg::SUSPEND_STATUS_SET_SUSPEND_BIT);
  assign set_enable  = wr_port && w1(wr_data, wr_strb, rhpc_pkg::ENABLE_STATUS_SET_ENABLE_BIT);
  assign clr_enable  = wr_port && w1(wr_data, wr_strb, rhpc_pkg::CONNECT_STATUS_CLEAR_ENABLE_BIT);
  assign clr_connect_chg = wr_port && w1(wr_data, wr_strb, rhpc_pkg::CONNECT_CHANGE_FLAG_BIT);
  assign clr_suspend_chg = wr_port && w1(wr_data, wr_strb, rhpc_pkg::SUSPEND_CHANGE_FLAG_BIT);
  assign clr_reset_chg   = wr_port && w1(wr_data, wr_strb, rhpc_pkg::RESET_CHANGE_FLAG_BIT);

  // ---------------- axi read channel ----------------
  assign rd_mapped = hit(s_axi_araddr, rhpc_pkg::PORT1_STATUS_CONTROL_OFF) ||
                     hit(s_axi_araddr, rhpc_pkg::ROOT_HUB_DESCRIPTOR_B_OFF);

  // read image; overcurrent bit and bits seven to five stay zero
  always_comb begin
    rd_value = 32'h00000000;
    if (hit(s_axi_araddr, rhpc_pkg::PORT1_STATUS_CONTROL_OFF)) begin
      rd_value[rhpc_pkg::CONNECT_STATUS_CLEAR_ENABLE_BIT] = ccs;
      rd_value[rhpc_pkg::ENABLE_STATUS_SET_ENABLE_BIT]    = pes;
      rd_value[rhpc_pkg::SUSPEND_STATUS_SET_SUSPEND_BIT]  = port_suspended;
      rd_value[rhpc_pkg::OVERCURRENT_CLEAR_SUSPEND_BIT]   = 1'b0;
      rd_value[rhpc_pkg::RESET_STATUS_SET_RESET_BIT]      = port_reset_drive;
      rd_value[rhpc_pkg::CONNECT_CHANGE_FLAG_BIT]         = connect_change_flag;
      rd_value[rhpc_pkg::SUSPEND_CHANGE_FLAG_BIT]         = pssc;
      rd_value[rhpc_pkg::RESET_CHANGE_FLAG_BIT]           = reset_change_flag;
    end else if (hit(s_axi_araddr, rhpc_pkg::ROOT_HUB_DESCRIPTOR_B_OFF)) begin
      rd_value[rhpc_pkg::NONREMOVABLE_DEVICE_MASK_BIT]    = nonremovable;
    end
  end

  // reads have no side effects, so data is captured at the address handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= rhpc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_mapped ? rhpc_pkg::RESP_OKAY : rhpc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ---------------- descriptor and connect status ----------------
  // nonremovable mask for port 1, written by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nonremovable <= rhpc_pkg::NONREMOVABLE_RESET;
    end else if (wr_desc && wr_strb[0]) begin
      nonremovable <= wr_data[rhpc_pkg::NONREMOVABLE_DEVICE_MASK_BIT];
    end
  end

  // connect status follows the pin, forced on for a nonremovable device;
  // ccs starts at 0 and the mask resets to 0, so a nonremovable port shows a rise once the mask is written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      attach_q <= 1'b0;
      ccs      <= 1'b0;
      ccs_q    <= 1'b0;
    end else begin
      attach_q <= dev_attached;
      ccs      <= attach_q || nonremovable;
      ccs_q    <= ccs;
    end
  end

  // ---------------- port sequence ----------------
  // reset wins over everything; suspend requests need a connected device
  always_comb begin
    next_state = state;
    case (state)
      rhpc_pkg::RHPC_IDLE: begin
        if (set_reset && ccs) begin
          next_state = rhpc_pkg::RHPC_RESET;
        end else if (set_suspend && ccs) begin
          next_state = rhpc_pkg::RHPC_SUSPEND;
        end
      end
      rhpc_pkg::RHPC_SUSPEND: begin
        if (set_reset && ccs) begin
          next_state = rhpc_pkg::RHPC_RESET;
        end else if (!ccs) begin
          next_state = rhpc_pkg::RHPC_IDLE;
        end else if (clr_suspend) begin
          next_state = rhpc_pkg::RHPC_RESUME;
        end
      end
      rhpc_pkg::RHPC_RESUME: begin
        if (set_reset && ccs) begin
          next_state = rhpc_pkg::RHPC_RESET;
        end else if (tmr_done || !ccs) begin
          next_state = rhpc_pkg::RHPC_IDLE;
        end
      end
      rhpc_pkg::RHPC_RESET: begin
        if (tmr_done) begin
          next_state = rhpc_pkg::RHPC_IDLE;
        end
      end
      default: begin
        next_state = rhpc_pkg::RHPC_IDLE;
      end
    endcase
  end

  // clear-suspend outside suspend falls through the case above untouched
  assign end_reset  = (state == rhpc_pkg::RHPC_RESET) && tmr_done;
  assign end_resume = (state == rhpc_pkg::RHPC_RESUME) && tmr_done;
  assign tmr_start  = (next_state != state) &&
                      ((next_state == rhpc_pkg::RHPC_RESET) ||
                       (next_state == rhpc_pkg::RHPC_RESUME));
  assign tmr_load   = (next_state == rhpc_pkg::RHPC_RESET) ?
                      RESET_CYCLES[rhpc_pkg::TIMER_W-1:0] :
                      RESUME_CYCLES[rhpc_pkg::TIMER_W-1:0];

  // one timer serves both sequences since they never overlap
  rhpc_seq_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (tmr_start),
    .load    (tmr_load),
    .busy    (),
    .done    (tmr_done)
  );

  // state and port drive lines come from flops set off the next state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state             <= rhpc_pkg::RHPC_IDLE;
      port_reset_drive  <= 1'b0;
      port_resume_drive <= 1'b0;
      port_suspended    <= 1'b0;
    end else begin
      state             <= next_state;
      port_reset_drive  <= (next_state == rhpc_pkg::RHPC_RESET);
      port_resume_drive <= (next_state == rhpc_pkg::RHPC_RESUME);
      port_suspended    <= (next_state == rhpc_pkg::RHPC_SUSPEND) ||
                           (next_state == rhpc_pkg::RHPC_RESUME);
    end
  end

  // ---------------- enable status ----------------
  // set events win over a clear in the same cycle; a disconnect disables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pes          <= 1'b0;
      port_enabled <= 1'b0;
    end else begin
      if (end_reset || end_resume || (set_enable && ccs)) begin
        pes          <= 1'b1;
        port_enabled <= 1'b1;
      end else if (clr_enable || (ccs_q && !ccs)) begin
        pes          <= 1'b0;
        port_enabled <= 1'b0;
      end
    end
  end

  // ---------------- change flags ----------------
  // connect change: attach or detach, or a request aimed at an empty port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      connect_change_flag <= 1'b0;
    end else if ((ccs != ccs_q) || (!ccs && (set_reset || set_enable || set_suspend))) begin
      connect_change_flag <= 1'b1;
    end else if (clr_connect_chg) begin
      connect_change_flag <= 1'b0;
    end
  end

  // suspend change only once the resume sequence has run out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pssc <= 1'b0;
    end else if (end_resume) begin
      pssc <= 1'b1;
    end else if (clr_suspend_chg) begin
      pssc <= 1'b0;
    end
  end

  // reset change marks the end of reset signaling
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_change_flag <= 1'b0;
    end else if (end_reset) begin
      reset_change_flag <= 1'b1;
    end else if (clr_reset_chg) begin
      reset_change_flag <= 1'b0;
    end
  end

endmodule

//--- design/rhpc_pkg.sv
// constants for the root hub port 1 low control byte and its register slave
// How it works
// - writing 1 to set-reset raises reset status and starts reset signaling; 0 ignored
// - reset status reads 1 exactly while reset signaling is driven on the port
// - clear-suspend write of 1 while suspended starts resume signaling
// - clear-suspend ignored when not suspended; writing 0 always ignored
// - overcurrent readback is 1 only after overcurrent; no input here, so reads 0
// - set-suspend write of 1 while connected sets suspend status and suspends port
// - set-suspend while disconnected does not suspend, it raises connect change
// - suspend status clears itself at end of resume and end of reset; here it clears when reset signaling starts
// - suspend status reads 1 while suspended and during resume
// - set-enable write of 1 while connected sets enable status
// - set-enable ignored while disconnected; writing 0 always ignored
// - enable status sets itself when a port reset completes
// - enable status sets itself when resume completes on a disabled port
// - connect status reads 1 with a device attached, 0 without
// - nonremovable mask bit makes connect status 1 after root hub reset; here the mask resets to 0, so connect status reads 1 once the mask is written
// - clear-enable write of 1 clears enable status; writing 0 does nothing
// - set-reset, set-enable or set-suspend while disconnected raise connect change
package rhpc_pkg;

  // register byte offsets
  localparam logic [7:0]  PORT1_STATUS_CONTROL_OFF = 8'h00;
  localparam logic [7:0]  ROOT_HUB_DESCRIPTOR_B_OFF = 8'h04;

  // port1_status_control field positions
  localparam int CONNECT_STATUS_CLEAR_ENABLE_BIT = 0;
  localparam int ENABLE_STATUS_SET_ENABLE_BIT    = 1;
  localparam int SUSPEND_STATUS_SET_SUSPEND_BIT  = 2;
  localparam int OVERCURRENT_CLEAR_SUSPEND_BIT   = 3;
  localparam int RESET_STATUS_SET_RESET_BIT      = 4;
  localparam int CONNECT_CHANGE_FLAG_BIT         = 16;
  localparam int SUSPEND_CHANGE_FLAG_BIT         = 18;
  localparam int RESET_CHANGE_FLAG_BIT           = 20;

  // root_hub_descriptor_b field position and reset value
  localparam int         NONREMOVABLE_DEVICE_MASK_BIT = 1;
  localparam logic       NONREMOVABLE_RESET           = 1'b0;

  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // signaling times
  localparam int CLK_HZ          = 25000000;
  localparam int USB_RESET_MS    = 10;
  localparam int USB_RESUME_MS   = 20;
  localparam int RESET_CYCLES    = USB_RESET_MS * (CLK_HZ / 1000);
  localparam int RESUME_CYCLES   = USB_RESUME_MS * (CLK_HZ / 1000);
  localparam int TIMER_W         = 20;

  // port sequence states
  typedef enum logic [1:0] {
    RHPC_IDLE    = 2'b00,
    RHPC_RESET   = 2'b01,
    RHPC_SUSPEND = 2'b10,
    RHPC_RESUME  = 2'b11
  } rhpc_state_t;

endpackage

//--- design/rhpc_seq_timer.sv
// one-shot down counter timing reset and resume signaling
`timescale 1ns/1ps
module rhpc_seq_timer (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         start,
  input  wire logic [rhpc_pkg::TIMER_W-1:0] load,
  output logic                              busy,
  output logic                              done
);

  logic [rhpc_pkg::TIMER_W-1:0] count;

  // a new start restarts the count even while busy, so reset can cut a resume short
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (start) begin
      count <= load;
      busy  <= 1'b1;
      done  <= 1'b0;
    end else if (busy && count <= 20'h00001) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b1;                         // one-cycle pulse
    end else begin
      count <= busy ? count - 20'h00001 : count;
      done  <= 1'b0;
    end
  end

endmodule

//--- dv/rhpc_usb_dev.sv
// behavioural usb device on root hub port 1: plugs in and times bus signaling
`timescale 1ns/1ps
module rhpc_usb_dev (
  input  wire logic clk,
  input  wire logic plug,
  input  wire logic port_reset_drive,
  input  wire logic port_resume_drive,
  output logic      dev_attached,
  output int        reset_len,
  output int        resume_len
);
  int rst_run;
  int res_run;

  // attach follows the bench's plug request one edge later, like a cable event;
  // unknown only until the first edge, which falls inside the held reset
  always @(posedge clk) dev_attached <= plug;

  // measure each stretch of signaling the host drives; kept after it ends
  // counters are two-state ints, so they start at zero without an initial block
  always @(posedge clk) begin
    if (port_reset_drive) rst_run <= rst_run + 1;
    else if (rst_run != 0) begin
      reset_len <= rst_run;
      rst_run <= 0;
    end
    if (port_resume_drive) res_run <= res_run + 1;
    else if (res_run != 0) begin
      resume_len <= res_run;
      res_run <= 0;
    end
  end
endmodule

//--- dv/rhpc_properties.sv
// concurrent checks on the port control block's outputs
`timescale 1ns/1ps
module rhpc_properties #(
  parameter int RESET_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        port_reset_drive,
  input wire logic        port_resume_drive,
  input wire logic        port_suspended,
  input wire logic        port_enabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  int         rst_cnt;
  logic [7:0] rd_addr;

  // length of the current reset signaling; a stuck timer shows up here
  always_ff @(posedge clk) begin
    if (sys_rst || !port_reset_drive) rst_cnt <= 0;
    else rst_cnt <= rst_cnt + 1;
  end

  // remember which word the pending read asked for
  always_ff @(posedge clk) begin
    if (sys_rst) rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end

  reset_by_write_a: assert property ($rose(port_reset_drive) |-> $rose(s_axi_bvalid))
    else $error("reset signaling started without a register write");
  reset_hold_a: assert property ($rose(port_reset_drive) |-> port_reset_drive[*8])
    else $error("reset signaling ended too soon");
  reset_bound_a: assert property (rst_cnt <= RESET_CYCLES + 2)
    else $error("reset signaling ran too long");
  suspend_by_write_a: assert property ($rose(port_suspended) |-> $rose(s_axi_bvalid))
    else $error("suspend entered without a register write");
  resume_in_suspend_a: assert property (port_resume_drive |-> port_suspended)
    else $error("suspend status low during resume");
  reset_ends_unsusp_a: assert property ($fell(port_reset_drive) |-> !port_suspended)
    else $error("suspend kept after reset end");
  resume_ends_unsusp_a: assert property ($fell(port_resume_drive) |-> !port_suspended)
    else $error("suspend kept after resume end");
  reset_ends_enabled_a: assert property ($fell(port_reset_drive) |-> port_enabled)
    else $error("port not enabled after reset end");
  enable_cause_a: assert property ($rose(port_enabled) |->
      $rose(s_axi_bvalid) || $fell(port_reset_drive) || $fell(port_resume_drive))
    else $error("port enabled without a cause");
  reserved_zero_a: assert property (s_axi_rvalid && rd_addr == rhpc_pkg::PORT1_STATUS_CONTROL_OFF
      |-> s_axi_rdata[7:5] == 3'h0 && !s_axi_rdata[3])
    else $error("reserved or overcurrent bits read nonzero");
endmodule

bind rhpc_top rhpc_properties #(.RESET_CYCLES(RESET_CYCLES)) rhpc_properties_inst (
  .clk(clk), .sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .port_reset_drive(port_reset_drive),
  .port_resume_drive(port_resume_drive), .port_suspended(port_suspended),
  .port_enabled(port_enabled));

//--- dv/rhpc_top_tb.sv
// register-level tests of the port control block against a device model
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module rhpc_top_tb;
  localparam int RST_C = 20;
  localparam int RES_C = 30;
  logic clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, plug, dev_attached;
  logic rst_drv, res_drv, susp, en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int bad_count, n_tests, reset_len, resume_len;

  rhpc_top #(.RESET_CYCLES(RST_C), .RESUME_CYCLES(RES_C)) rhpc_top_inst (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dev_attached(dev_attached), .port_reset_drive(rst_drv), .port_resume_drive(res_drv),
    .port_suspended(susp), .port_enabled(en));

  rhpc_usb_dev rhpc_usb_dev_inst (
    .clk(clk), .plug(plug), .port_reset_drive(rst_drv), .port_resume_drive(res_drv),
    .dev_attached(dev_attached), .reset_len(reset_len), .resume_len(resume_len));

  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // axi4-lite write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    `CHK(bresp, er)
    if (i == 100) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // axi4-lite read, compared under a mask of the bits of interest
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    int i;
    logic [1:0] xr;
    // only the two mapped words answer okay
    xr = (a == rhpc_pkg::PORT1_STATUS_CONTROL_OFF || a == rhpc_pkg::ROOT_HUB_DESCRIPTOR_B_OFF) ?
         rhpc_pkg::RESP_OKAY : rhpc_pkg::RESP_SLVERR;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    `CHK(rdata & m, e & m)
    `CHK(rresp, xr)
    if (i == 100) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // wait out reset or resume signaling; the bound is well beyond both times
  task automatic idle_port();
    int i;
    for (i = 0; i < 200 && (rst_drv !== 1'b0 || res_drv !== 1'b0); i++) @(posedge clk);
    if (i == 200) begin
      bad_count++;
      end_of_test();
    end
  endtask

  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] NOSC = 32'hfffb_ffff; // suspend change left out
  localparam logic [1:0] OK = rhpc_pkg::RESP_OKAY;
  int k;
  logic [31:0] cmd [3] = '{32'h10, 32'h02, 32'h04};

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, plug} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
    bad_count = 0; n_tests = 0; sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(8'h00, 32'h0, ALL);
    wr(8'h08, 32'h0, rhpc_pkg::RESP_SLVERR);
    rd_chk(8'h08, 32'h0, ALL);
    // requests to an empty port only flag a connect change
    for (k = 0; k < 3; k++) begin
      wr(8'h00, cmd[k], OK);
      rd_chk(8'h00, 32'h0001_0000, ALL);
      `CHK({rst_drv, susp, en}, 3'h0)
      wr(8'h00, 32'h0001_0000, OK);
    end
    $display("test empty port done");
    plug <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'h00, 32'h0001_0001, ALL);
    wr(8'h00, 32'h0001_0000, OK);
    wr(8'h00, 32'h0, OK);
    wr(8'h00, 32'h8, OK);
    rd_chk(8'h00, 32'h1, ALL);
    wr(8'h00, 32'h2, OK);
    rd_chk(8'h00, 32'h3, ALL);
    `CHK(en, 1'b1)
    wr(8'h00, 32'h1, OK);
    rd_chk(8'h00, 32'h1, ALL);
    $display("test enable done");
    wr(8'h00, 32'h10, OK);
    `CHK(rst_drv, 1'b1)
    rd_chk(8'h00, 32'h11, ALL);
    idle_port();
    rd_chk(8'h00, 32'h0010_0003, NOSC);
    `CHK(reset_len >= RST_C && reset_len <= RST_C + 2, 1'b1)
    wr(8'h00, 32'h0014_0000, OK);
    $display("test port reset done");
    wr(8'h00, 32'h4, OK);
    rd_chk(8'h00, 32'h7, ALL);
    `CHK(susp, 1'b1)
    wr(8'h00, 32'h1, OK);
    wr(8'h00, 32'h8, OK);
    `CHK(res_drv, 1'b1)
    rd_chk(8'h00, 32'h5, ALL);
    idle_port();
    rd_chk(8'h00, 32'h0004_0003, ALL);
    `CHK(resume_len >= RES_C - 2 && resume_len <= RES_C + 2, 1'b1)
    wr(8'h00, 32'h0004_0000, OK);
    $display("test suspend resume done");
    wr(8'h00, 32'h4, OK);
    wr(8'h00, 32'h10, OK);
    idle_port();
    rd_chk(8'h00, 32'h0010_0003, NOSC);
    wr(8'h00, 32'h0014_0000, OK);
    plug <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(8'h00, 32'h0001_0000, ALL);
    // a nonremovable mask reports the port connected with no device on the pin
    wr(8'h00, 32'h0001_0000, OK);
    wr(8'h04, 32'h2, OK);
    rd_chk(8'h04, 32'h2, ALL);
    rd_chk(8'h00, 32'h0001_0001, ALL);
    $display("test reset from suspend and detach done");
    end_of_test();
  end
endmodule
